// ---- hw/adc_sample_output_pipeline.sv ----
// converter sample pipeline, output stage, strobe and power modes
`timescale 1ns/1ns
module adc_sample_output_pipeline
   import adc_pipe_pkg::*;
#(
   parameter int PD_WAIT_CYC  = PD_RECOVERY_CYC,
   parameter int SLP_WAIT_CYC = SLP_RECOVERY_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              conv_clk,
   input  wire logic [WORD_W-1:0] sample_code,
   input  wire logic [1:0]        low_power_select,
   input  wire logic [1:0]        clock_and_format_select,
   output logic [WORD_W-1:0]      data_out,
   output logic                   output_word_strobe,
   output logic                   data_valid,
   output logic                   diff_clock_mode
);
   if (PD_WAIT_CYC < 1 || PD_WAIT_CYC >= (1 << WAIT_W) ||
       SLP_WAIT_CYC < 1 || SLP_WAIT_CYC >= (1 << WAIT_W) ||
       PIPE_HALF < 2)
      $error("recovery counts out of range");

   // two-stage synchronisers for conv_clk, sample_code and both select pins
   logic                conv_s1_ff, conv_s2_ff, conv_s3_ff;
   logic [WORD_W-1:0]   code_s1_ff, code_s2_ff;
   logic [1:0]          lp_s1_ff, lp_s2_ff;
   logic [1:0]          sel_s1_ff, sel_s2_ff;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         conv_s1_ff <= 1'b0;
         conv_s2_ff <= 1'b0;
         conv_s3_ff <= 1'b0;
         code_s1_ff <= ZERO_WORD;
         code_s2_ff <= ZERO_WORD;
         lp_s1_ff   <= LP_NORMAL;
         lp_s2_ff   <= LP_NORMAL;
         sel_s1_ff  <= 2'h0;
         sel_s2_ff  <= 2'h0;
      end else if (ce) begin
         conv_s1_ff <= conv_clk;
         conv_s2_ff <= conv_s1_ff;
         conv_s3_ff <= conv_s2_ff;
         code_s1_ff <= sample_code;
         code_s2_ff <= code_s1_ff;
         lp_s1_ff   <= low_power_select;
         lp_s2_ff   <= lp_s1_ff;
         sel_s1_ff  <= clock_and_format_select;
         sel_s2_ff  <= sel_s1_ff;
      end
   end

   wire conv_fall = conv_s3_ff & ~conv_s2_ff;
   wire conv_rise = ~conv_s3_ff & conv_s2_ff;
   wire conv_edge = conv_fall | conv_rise;
   wire twos_mode = sel_s2_ff[SEL_TWOS];
   wire lp_normal = (lp_s2_ff == LP_NORMAL);

   // any code other than normal or sleep means power-down
   function automatic pwr_state_type lp_target(input logic [1:0] code);
      lp_target = (code == LP_SLEEP) ? PWR_SLEEP : PWR_DOWN;
   endfunction

   pwr_state_type       lp_goal;
   assign lp_goal = lp_target(lp_s2_ff);

   // power mode sequencing
   pwr_state_type       pwr_ff, nxt_pwr;
   logic [WAIT_W-1:0]   wait_ff, nxt_wait;

   always_comb begin
      nxt_pwr  = pwr_ff;
      nxt_wait = wait_ff;
      case (pwr_ff)
         PWR_RUN: begin
            if (!lp_normal)
               nxt_pwr = lp_goal; // [R10]
         end
         PWR_SLEEP, PWR_DOWN: begin
            if (lp_normal) begin
               nxt_pwr  = PWR_WAKE;
               nxt_wait = (pwr_ff == PWR_SLEEP) ?
                          WAIT_W'(SLP_WAIT_CYC - 1) :
                          WAIT_W'(PD_WAIT_CYC - 1); // [R05]
            end else begin
               nxt_pwr = lp_goal; // [R10]
            end
         end
         PWR_WAKE: begin
            if (!lp_normal)
               nxt_pwr = lp_goal;
            else if (wait_ff == '0)
               nxt_pwr = PWR_RUN;
            else
               nxt_wait = wait_ff - 1'b1; // [R05]
         end
         default: nxt_pwr = PWR_DOWN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pwr_ff  <= PWR_RUN;
         wait_ff <= '0;
      end else if (ce) begin
         pwr_ff  <= nxt_pwr;
         wait_ff <= nxt_wait;
      end
   end

   wire running = (pwr_ff == PWR_RUN);

   // each sample occupies two half-cycle slots; it reaches the last
   // slot on the falling edge 8 cycles after its falling edge
   logic [WORD_W-1:0] pipe_ff [PIPE_HALF];
   wire  [WORD_W-1:0] stage_in = conv_fall ? code_s2_ff : pipe_ff[0];
   wire  [WORD_W-1:0] pipe_top = pipe_ff[PIPE_HALF-1];
   wire  [WORD_W-1:0] coded    = twos_mode ? (pipe_top ^ MSB_FLIP)
                                           : pipe_top; // [R07] [R11]

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < PIPE_HALF; i++)
            pipe_ff[i] <= ZERO_WORD;
      end else if (ce && conv_edge) begin
         pipe_ff[0] <= stage_in; // [R01]
         for (int i = 1; i < PIPE_HALF; i++)
            pipe_ff[i] <= pipe_ff[i-1]; // [R02]
      end
   end

   // data pins load on the falling edge, so data changes as the
   // strobe falls and is stable at its rising edge
   logic [WORD_W-1:0] data_ff;
   logic              strobe_ff, valid_ff, diff_ff;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         data_ff   <= ZERO_WORD;
         strobe_ff <= 1'b0;
         valid_ff  <= 1'b0;
         diff_ff   <= 1'b0;
      end else if (ce) begin
         // taken from s2 so the strobe falls in the cycle the data loads
         strobe_ff <= conv_s2_ff & running; // [R09]
         diff_ff   <= sel_s2_ff[SEL_DIFF_CLK]; // [R11]
         if (!running)
            valid_ff <= 1'b0; // [R05]
         else if (conv_fall)
            valid_ff <= 1'b1;
         if (conv_fall && running)
            data_ff <= coded; // [R03] [R04] [R06]
      end
   end

   assign data_out           = data_ff;
   assign output_word_strobe = strobe_ff;
   assign data_valid         = valid_ff;
   assign diff_clock_mode    = diff_ff;

   fall_sample_a: assert property ( // [R01]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_fall |=> pipe_ff[0] == $past(code_s2_ff))
      else $error("sample not taken on falling edge");

   pipe_shift_a: assert property ( // [R02]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_edge |=> pipe_top == $past(pipe_ff[PIPE_HALF-2]))
      else $error("pipeline slot did not advance");

   word_each_a: assert property ( // [R03]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_fall && running |=> data_out == $past(coded))
      else $error("no word loaded on converter cycle");

   valid_on_fall_a: assert property ( // [R03]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_fall && running |=> data_valid)
      else $error("valid not raised by a loaded word");

   pins_on_fall_a: assert property ( // [R04]
      @(posedge ref_clk) disable iff (!nrst)
      data_out != $past(data_out) |-> $past(conv_fall && ce && running))
      else $error("data changed away from falling edge");

   freeze_hold_a: assert property ( // [R04]
      @(posedge ref_clk) disable iff (!nrst)
      !ce |=> $stable(data_out) && $stable(output_word_strobe))
      else $error("outputs moved while enable low");

   wake_wait_a: assert property ( // [R05]
      @(posedge ref_clk) disable iff (!nrst)
      ce && pwr_ff == PWR_SLEEP && lp_normal |=> (!data_valid) [*2])
      else $error("data valid too soon after sleep");

   wake_count_a: assert property ( // [R05]
      @(posedge ref_clk) disable iff (!nrst)
      ce && pwr_ff == PWR_WAKE && lp_normal && wait_ff != '0
      |=> pwr_ff == PWR_WAKE)
      else $error("wake wait cut short");

   idle_invalid_a: assert property ( // [R05]
      @(posedge ref_clk) disable iff (!nrst)
      ce && !running |=> !data_valid)
      else $error("valid while not running");

   offset_code_a: assert property ( // [R06]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_fall && running && !twos_mode
      |=> data_out == $past(pipe_top))
      else $error("offset binary code altered");

   twos_mid_a: assert property ( // [R07]
      @(posedge ref_clk) disable iff (!nrst)
      ce && conv_fall && running && twos_mode
      |=> data_out[WORD_W-1] != $past(pipe_top[WORD_W-1]))
      else $error("two's complement msb not inverted");

   strobe_rate_a: assert property ( // [R09]
      @(posedge ref_clk) disable iff (!nrst)
      ce && running && conv_fall |=> !output_word_strobe)
      else $error("strobe not following converter clock");

   strobe_rise_a: assert property ( // [R09]
      @(posedge ref_clk) disable iff (!nrst)
      ce && running && conv_rise |=> output_word_strobe)
      else $error("strobe not rising with converter clock");

   low_power_a: assert property ( // [R10]
      @(posedge ref_clk) disable iff (!nrst)
      ce && !lp_normal |=> ##1 !data_valid)
      else $error("valid held in low power");
endmodule

// ---- hw/adc_pipe_pkg.sv ----
// constants for the sampling converter output pipeline
// Summary of operation
// [R01] each sample is taken a short delay after a falling converter edge.
// [R02] a word reaches the output stage 8.5 converter cycles after sampling; the code loads data_out 9 cycles after.
// [R03] a new word leaves every converter cycle, lagging its sample.
// [R04] the data pins change on the falling converter edge after a delay.
// [R05] data is valid again 3.0 ms after power-down and 100 us after sleep.
// [R06] every code of the full range can appear at the output unaltered.
// [R07] in offset binary, mid-scale lies between codes 8191 and 8192.
// [R08] the outside clock runs between 5 and 155 million cycles per second.
// [R09] the ready strobe runs at the converter rate, data moving on its fall.
// [R10] the low-power select picks power-down, sleep or normal operation.
// [R11] the format select picks clock mode and offset or two's complement.
package adc_pipe_pkg;
   localparam int  WORD_W          = 14;
   localparam real CLK_PERIOD_NS   = 50.0;
   localparam real LATENCY_CYCLES  = 8.5;
   localparam int  PIPE_HALF       = int'(LATENCY_CYCLES * 2.0);
   localparam real APERTURE_NS     = 0.5;
   localparam real OUT_DELAY_NS    = 4.0;
   localparam int  APERTURE_CYC    =
      (int'($floor(APERTURE_NS / CLK_PERIOD_NS)) < 1) ? 1 :
      int'($floor(APERTURE_NS / CLK_PERIOD_NS));
   localparam int  OUT_DELAY_CYC   =
      (int'($floor(OUT_DELAY_NS / CLK_PERIOD_NS)) < 1) ? 1 :
      int'($floor(OUT_DELAY_NS / CLK_PERIOD_NS));
   localparam real PD_RECOVERY_MS  = 3.0;
   localparam real SLP_RECOVERY_US = 100.0;
   localparam int  PD_RECOVERY_CYC =
      int'($ceil(PD_RECOVERY_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int  SLP_RECOVERY_CYC =
      int'($ceil(SLP_RECOVERY_US * 1.0e3 / CLK_PERIOD_NS));
   localparam int  WAIT_W          = 20;
   // low-power select codes
   localparam logic [1:0] LP_NORMAL = 2'h0;
   localparam logic [1:0] LP_SLEEP  = 2'h1;
   // clock and format select bit positions
   localparam int  SEL_DIFF_CLK    = 0;
   localparam int  SEL_TWOS        = 1;
   localparam logic [WORD_W-1:0] MSB_FLIP = 14'h2000;
   localparam logic [WORD_W-1:0] ZERO_WORD = 14'h0000;

   typedef enum logic [3:0] {
      PWR_RUN   = 4'h1,
      PWR_SLEEP = 4'h2,
      PWR_DOWN  = 4'h4,
      PWR_WAKE  = 4'h8
   } pwr_state_type;
endpackage

// ---- test/word_capture.sv ----
// capture logic on the far side, latching words on the ready strobe
`timescale 1ns/1ns
module word_capture
   import adc_pipe_pkg::*;
(
   input  wire logic              output_word_strobe,
   input  wire logic [WORD_W-1:0] data_out,
   output logic [WORD_W-1:0]      captured_ff
);
   // rising strobe is mid-eye, data moves on the falling one
   always_ff @(posedge output_word_strobe) begin
      captured_ff <= data_out;
   end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the converter output pipeline
`timescale 1ns/1ns
module testbench
   import adc_pipe_pkg::*;
;
   logic              ref_clk;
   logic              nrst;
   logic              ce;
   logic              conv_clk;
   logic [WORD_W-1:0] sample_code;
   logic [1:0]        low_power_select;
   logic [1:0]        clock_and_format_select;
   logic [WORD_W-1:0] data_out;
   logic              output_word_strobe;
   logic              data_valid;
   logic              diff_clock_mode;
   logic [WORD_W-1:0] captured;
   logic [WORD_W-1:0] hist [$];
   int                fail_count;
   int                cmp_count;

   // short wake waits keep the run brief
   adc_sample_output_pipeline #(.PD_WAIT_CYC(40), .SLP_WAIT_CYC(12)) DUT (
      .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .conv_clk(conv_clk),
      .sample_code(sample_code), .low_power_select(low_power_select),
      .clock_and_format_select(clock_and_format_select),
      .data_out(data_out), .output_word_strobe(output_word_strobe),
      .data_valid(data_valid), .diff_clock_mode(diff_clock_mode));
   word_capture partner (.output_word_strobe(output_word_strobe),
      .data_out(data_out), .captured_ff(captured));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [WORD_W-1:0] exp,
                        input logic [WORD_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // mid-scale pair, then sweeping values and their inverses
   function automatic logic [WORD_W-1:0] code_of(input int k);
      logic [WORD_W-1:0] mix;
      mix = 14'(k) * 14'h0b6d;
      case (k % 4)
         0: code_of = 14'h1fff;
         1: code_of = 14'h2000;
         2: code_of = mix;
         default: code_of = ~mix;
      endcase
   endfunction

   // one 400 ns link period, edges half a ref cycle off the sampling edge
   task automatic conv_period(input logic [WORD_W-1:0] code);
      conv_clk = 1'b1; // slowed to suit the sampling clock
      sample_code = code;
      hist.push_back(code);
      repeat (4) @(negedge ref_clk);
      conv_clk = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic stream(input logic [1:0] sel, input int n);
      logic [WORD_W-1:0] flip;
      int                last;
      clock_and_format_select = sel;
      flip = sel[SEL_TWOS] ? MSB_FLIP : ZERO_WORD;
      for (int k = 0; k < n; k++) begin
         conv_period(code_of(k));
         last = hist.size() - 1;
         if (k >= 10) begin
            check("data_out", hist[last-9] ^ flip, data_out);
            check("captured", hist[last-10] ^ flip, captured);
            check("data_valid", 14'h0001, {13'h0, data_valid});
         end
      end
      check("diff_mode", {13'h0, sel[0]}, {13'h0, diff_clock_mode});
      $display("stream test done, select %h", sel);
   endtask

   task automatic low_power(input logic [1:0] mode, input int wait_per);
      low_power_select = mode;
      repeat (2) conv_period(code_of(3));
      conv_clk = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("strobe", ZERO_WORD, {13'h0, output_word_strobe});
      check("valid", ZERO_WORD, {13'h0, data_valid});
      low_power_select = LP_NORMAL;
      repeat (wait_per) conv_period(code_of(2));
      check("valid", ZERO_WORD, {13'h0, data_valid});
      repeat (3) conv_period(code_of(2));
      check("valid", 14'h0001, {13'h0, data_valid});
      $display("low power test done, mode %h", mode);
   endtask

   // converter edges seen while the enable is low must be lost
   task automatic freeze();
      logic [WORD_W-1:0] held;
      held = hist[hist.size()-10];
      ce = 1'b0;
      conv_clk = 1'b1;
      repeat (4) @(negedge ref_clk);
      conv_clk = 1'b0;
      repeat (4) @(negedge ref_clk);
      check("frozen data", held, data_out);
      ce = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("data after freeze", held, data_out);
      check("freeze strobe", ZERO_WORD, {13'h0, output_word_strobe});
      $display("freeze test done");
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      complete_run();
   end

   initial begin
      fail_count = 0;
      cmp_count = 0;
      nrst = 1'b0;
      ce = 1'b1;
      conv_clk = 1'b0;
      sample_code = ZERO_WORD;
      low_power_select = LP_NORMAL;
      clock_and_format_select = 2'h0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      check("reset data", ZERO_WORD, data_out);
      stream(2'h0, 30);
      freeze();
      stream(2'h2, 30);
      stream(2'h1, 14);
      stream(2'h3, 14);
      low_power(LP_SLEEP, 1);
      low_power(2'h2, 5);
      low_power(2'h3, 5);
      stream(2'h0, 12);
      complete_run();
   end
endmodule
